// ===== pkg/hiccup_pkg.sv
package hiccup_pkg;

  // ****************************************
  // Clock and time base
  // ****************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int CNT_W = 20;

  // ****************************************
  // Documented times, in their own units
  // ****************************************
  localparam int POR_DELAY_US = 6800;
  localparam int SAMPLE_US = 3400;
  localparam int SOFT_START_US = 6800;
  localparam int REFRESH_US = 100;
  localparam int BLANK_NS = 200;
  localparam int MIN_LOW_NS = 425;
  localparam int SW_SLOW_HZ = 300_000;
  localparam int SW_FAST_HZ = 600_000;

  // ****************************************
  // Derived cycle counts
  // ****************************************
  localparam int POR_DELAY_CYC = POR_DELAY_US * CLK_MHZ;
  localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
  localparam int SOFT_START_CYC = SOFT_START_US * CLK_MHZ;
  localparam int REFRESH_CYC = REFRESH_US * CLK_MHZ;
  localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int MIN_LOW_CYC = (MIN_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int PERIOD_SLOW_CYC = CLK_HZ / SW_SLOW_HZ;
  localparam int PERIOD_FAST_CYC = CLK_HZ / SW_FAST_HZ;

  // ****************************************
  // Ramp and threshold constants
  // ****************************************
  localparam int SS_STEPS = 64;
  localparam logic [5:0] SS_LAST_STEP = 6'h3F;
  localparam logic [5:0] SS_ZERO_STEP = 6'h00;
  localparam logic [8:0] DISABLE_MV = 9'h12C;
  localparam logic [8:0] MAX_DETECT_MV = 9'h1DB;
  localparam logic [1:0] NARROW_LIMIT = 2'h3;

  typedef enum {
    ST_POR_WAIT,
    ST_SAMPLE,
    ST_DUMMY1,
    ST_DUMMY2,
    ST_SOFT,
    ST_RUN,
    ST_SHUT
  } seq_state_type;

  // Sampled resistor voltage and presence, as seen at the end of the sample
  typedef struct packed {
    logic open;
    logic [8:0] level_mv;
  } sense_type;

  typedef struct packed {
    logic high;
    logic low;
  } gate_pair_type;

endpackage

// ===== core/soft_start_ramp.sv
`timescale 1ns/10ps
`default_nettype none

module soft_start_ramp
  import hiccup_pkg::*;
#(
  parameter int STEP_CYCLES = SOFT_START_CYC / SS_STEPS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  output logic [5:0] step,
  output logic busy,
  output logic done
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [5:0] next_step;
  logic next_busy;
  logic next_done;

  // ****************************************
  // Ramp: 64 equal steps, restart on start
  // ****************************************
  always_comb begin
    next_cnt = cnt;
    next_step = step;
    next_busy = busy;
    next_done = 1'b0;
    if (start) begin
      next_cnt = '0;
      next_step = SS_ZERO_STEP;
      next_busy = 1'b1;
    end else if (busy) begin
      if (cnt == CNT_W'(STEP_CYCLES - 1)) begin
        next_cnt = '0;
        if (step == SS_LAST_STEP) begin
          next_busy = 1'b0;
          next_done = 1'b1;
        end else begin
          next_step = step + 6'h01;
        end
      end else begin
        next_cnt = cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      step <= 6'h00;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      step <= next_step;
      busy <= next_busy;
      done <= next_done;
    end
  end

endmodule

`default_nettype wire

// ===== core/buck_fault_hiccup_sequencer.sv
// Operation
// - Threshold sample accepted from 0 to 475mV
// - Sample above 0.3V disables overcurrent guard
// - Absent resistor disables overcurrent guard
// - Overcurrent stops both gates immediately
// - Two dummy soft-starts before each retry attempt; first start ramps directly
// - Trip during real ramp restarts dummy pair
// - Hiccup period between 13.6ms and 20.4ms
// - Fault gone: ramp completes, regulation continues
// - Guard active in soft-start, same sequence
// - Enable pin low holds shutdown
// - Fixed switching frequency per variant
// - Sequence timing independent of switching clock
// - Long high-side on forces one low cycle
// - Boot refresh works with guard disabled
// - Each soft-start: 64 steps over 6.8ms
// - Third narrow low pulse stretched to 425ns while guard active
// - Trip window 200ns after low rise
// - Enable release resamples; retries reuse threshold
`timescale 1ns/10ps
`default_nettype none

module buck_fault_hiccup_sequencer
  import hiccup_pkg::*;
#(
  parameter bit FAST_VARIANT = 1'b0,
  parameter int POR_DELAY_CYCLES = POR_DELAY_CYC,
  parameter int SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int SOFT_START_CYCLES = SOFT_START_CYC,
  parameter int REFRESH_CYCLES = REFRESH_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable_pin,
  input wire logic trip_cmp_pin,
  input wire sense_type trip_set_sense,
  input wire logic pwm_request,
  output logic high_side_gate_drive,
  output logic low_side_gate_drive,
  output logic [5:0] ref_step,
  output logic [8:0] trip_level_mv,
  output logic overcurrent_guard,
  output logic regulating
);

  localparam int PERIOD_CYC = FAST_VARIANT ? PERIOD_FAST_CYC : PERIOD_SLOW_CYC;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic en_sync;
  logic oc_sync;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
    end else begin
      sync1 <= {trip_cmp_pin, enable_pin};
      sync2 <= sync1;
    end
  end

  assign en_sync = sync2[0];
  assign oc_sync = sync2[1];

  // ****************************************
  // Sequencer
  // ****************************************
  seq_state_type state;
  seq_state_type next_state;
  logic [CNT_W-1:0] wait_cnt;
  logic [CNT_W-1:0] next_wait_cnt;
  logic [8:0] next_trip_level_mv;
  logic next_overcurrent_guard;
  logic ss_start;
  logic next_ss_start;
  logic ss_busy;
  logic ss_done;
  logic [5:0] ss_step;
  logic trip;
  logic sw_on;

  soft_start_ramp #(
    .STEP_CYCLES(SOFT_START_CYCLES / SS_STEPS)
  ) u_ramp (
    .clk(clk),
    .rst(rst),
    .start(ss_start),
    .step(ss_step),
    .busy(ss_busy),
    .done(ss_done)
  );

  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    next_trip_level_mv = trip_level_mv;
    next_overcurrent_guard = overcurrent_guard;
    next_ss_start = 1'b0;
    if (!en_sync) begin
      next_state = ST_SHUT;
      next_wait_cnt = '0;
    end else begin
      case (state)
        ST_SHUT: begin
          next_state = ST_POR_WAIT;
          next_wait_cnt = '0;
        end
        ST_POR_WAIT: begin
          next_wait_cnt = wait_cnt + CNT_W'(1);
          if (wait_cnt == CNT_W'(POR_DELAY_CYCLES - 1)) begin
            next_state = ST_SAMPLE;
            next_wait_cnt = '0;
          end
        end
        ST_SAMPLE: begin
          next_wait_cnt = wait_cnt + CNT_W'(1);
          if (wait_cnt == CNT_W'(SAMPLE_CYCLES - 1)) begin
            next_wait_cnt = '0;
            next_trip_level_mv = (trip_set_sense.level_mv > MAX_DETECT_MV) ?
                                 MAX_DETECT_MV : trip_set_sense.level_mv;
            next_overcurrent_guard = !trip_set_sense.open &&
                                     (trip_set_sense.level_mv <= DISABLE_MV);
            next_state = ST_SOFT;
            next_ss_start = 1'b1;
          end
        end
        ST_DUMMY1: begin
          // A done pulse left over from a cut real ramp must not count
          if (ss_done && !ss_start) begin
            next_state = ST_DUMMY2;
            next_ss_start = 1'b1;
          end
        end
        ST_DUMMY2: begin
          if (ss_done && !ss_start) begin
            next_state = ST_SOFT;
            next_ss_start = 1'b1;
          end
        end
        ST_SOFT: begin
          if (trip) begin
            next_state = ST_DUMMY1;
            next_ss_start = 1'b1;
          end else if (ss_done) begin
            next_state = ST_RUN;
          end
        end
        ST_RUN: begin
          if (trip) begin
            next_state = ST_DUMMY1;
            next_ss_start = 1'b1;
          end
        end
        default: begin
          next_state = ST_SHUT;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_POR_WAIT;
      wait_cnt <= '0;
      trip_level_mv <= 9'h000;
      overcurrent_guard <= 1'b0;
      ss_start <= 1'b0;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
      trip_level_mv <= next_trip_level_mv;
      overcurrent_guard <= next_overcurrent_guard;
      ss_start <= next_ss_start;
    end
  end

  // ****************************************
  // Gate drive, stretching, boot refresh
  // ****************************************
  logic [8:0] period_cnt;
  logic [8:0] next_period_cnt;
  logic [8:0] low_width;
  logic [8:0] next_low_width;
  logic [8:0] low_run;
  logic [8:0] next_low_run;
  logic [CNT_W-1:0] high_run;
  logic [CNT_W-1:0] next_high_run;
  logic [1:0] narrow_cnt;
  logic [1:0] next_narrow_cnt;
  logic [8:0] stretch_cnt;
  logic [8:0] next_stretch_cnt;
  logic refresh;
  logic next_refresh;
  gate_pair_type next_gates;
  logic [5:0] next_ref_step;
  logic next_regulating;
  logic period_start;
  logic low_force;

  assign sw_on = (state == ST_SOFT) || (state == ST_RUN);
  assign period_start = (period_cnt == 9'h000);
  assign trip = overcurrent_guard && sw_on && low_side_gate_drive && oc_sync &&
                (low_run >= 9'(BLANK_CYC));

  always_comb begin
    next_period_cnt = (period_cnt == 9'(PERIOD_CYC - 1)) ?
                      9'h000 : period_cnt + 9'h001;
    next_narrow_cnt = narrow_cnt;
    next_stretch_cnt = (stretch_cnt != 9'h000) ? stretch_cnt - 9'h001 : 9'h000;
    next_refresh = refresh;
    next_low_width = low_width;
    if (period_start) begin
      next_refresh = sw_on && (high_run >= CNT_W'(REFRESH_CYCLES));
      next_low_width = 9'h000;
      if (!overcurrent_guard || !sw_on) begin
        next_narrow_cnt = 2'h0;
      end else if (low_width < 9'(MIN_LOW_CYC)) begin
        // Two narrow pulses seen: the coming third one is stretched
        if (narrow_cnt == NARROW_LIMIT - 2'h2) begin
          next_narrow_cnt = 2'h0;
          next_stretch_cnt = 9'(MIN_LOW_CYC);
        end else begin
          next_narrow_cnt = narrow_cnt + 2'h1;
        end
      end else begin
        next_narrow_cnt = 2'h0;
      end
    end else if (low_side_gate_drive) begin
      next_low_width = low_width + 9'h001;
    end
    low_force = (stretch_cnt != 9'h000) || refresh;
    next_gates.high = sw_on && !trip && pwm_request && !low_force;
    next_gates.low = sw_on && !trip && (!pwm_request || low_force);
    next_low_run = !next_gates.low ? 9'h000 :
                   (low_run == 9'h1FF) ? low_run : low_run + 9'h001;
    next_high_run = !next_gates.high ? '0 :
                    (high_run == CNT_W'(REFRESH_CYCLES)) ? high_run : high_run + CNT_W'(1);
    next_ref_step = (!sw_on || ss_start) ? SS_ZERO_STEP : (ss_busy ? ss_step : SS_LAST_STEP);
    next_regulating = (state == ST_RUN);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      period_cnt <= 9'h000;
      low_width <= 9'h000;
      low_run <= 9'h000;
      high_run <= '0;
      narrow_cnt <= 2'h0;
      stretch_cnt <= 9'h000;
      refresh <= 1'b0;
      high_side_gate_drive <= 1'b0;
      low_side_gate_drive <= 1'b0;
      ref_step <= 6'h00;
      regulating <= 1'b0;
    end else begin
      period_cnt <= next_period_cnt;
      low_width <= next_low_width;
      low_run <= next_low_run;
      high_run <= next_high_run;
      narrow_cnt <= next_narrow_cnt;
      stretch_cnt <= next_stretch_cnt;
      refresh <= next_refresh;
      high_side_gate_drive <= next_gates.high;
      low_side_gate_drive <= next_gates.low;
      ref_step <= next_ref_step;
      regulating <= next_regulating;
    end
  end

endmodule

`default_nettype wire

// ===== bench/buck_fault_hiccup_sequencer_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Checker
// ****
module buck_fault_hiccup_sequencer_chk
  import hiccup_pkg::*;
#(
  parameter int REFRESH_CYCLES = REFRESH_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable_pin,
  input wire logic trip_cmp_pin,
  input wire logic high_side_gate_drive,
  input wire logic low_side_gate_drive,
  input wire logic [5:0] ref_step,
  input wire logic [8:0] trip_level_mv,
  input wire logic overcurrent_guard,
  input wire logic regulating
);
  logic [15:0] low_run;
  logic [15:0] high_run;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_run <= 16'h0000;
      high_run <= 16'h0000;
    end else begin
      low_run <= low_side_gate_drive ? low_run + 16'h0001 : 16'h0000;
      high_run <= high_side_gate_drive ? high_run + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_LEVEL_RANGE: assert property (trip_level_mv <= MAX_DETECT_MV)
    else $error("stored threshold above range");
  AST_GUARD_LEVEL: assert property (overcurrent_guard |-> trip_level_mv <= DISABLE_MV)
    else $error("guard on with level above disable");
  AST_TRIP_OFF: assert property ((overcurrent_guard && low_side_gate_drive && trip_cmp_pin
    && low_run == 16'(BLANK_CYC - 4)) ##1 (low_side_gate_drive && trip_cmp_pin) [*3]
    |-> ##[1:3] (!high_side_gate_drive && !low_side_gate_drive))
    else $error("gates still on after trip");
  AST_SOFT_TRIP: assert property ((ref_step != SS_ZERO_STEP && ref_step != SS_LAST_STEP
    && overcurrent_guard && low_side_gate_drive && trip_cmp_pin
    && low_run == 16'(BLANK_CYC - 4)) ##1 (low_side_gate_drive && trip_cmp_pin) [*3]
    |-> ##[1:4] (ref_step == SS_ZERO_STEP))
    else $error("ramp not restarted after trip");
  AST_RUN_TOP: assert property (regulating |-> ref_step == 6'h3F)
    else $error("regulating below full reference");
  AST_HOLD_OFF: assert property (!enable_pin [*5]
    |-> !high_side_gate_drive && !low_side_gate_drive && !regulating)
    else $error("active while enable low");
  AST_REFRESH: assert property (high_run <= REFRESH_CYCLES + 400)
    else $error("high side on too long");
  AST_STEP: assert property ($changed(ref_step)
    |-> ref_step == $past(ref_step) + 6'h01 || ref_step == 6'h00)
    else $error("reference step jump");
endmodule
`default_nettype wire

// ===== bench/switch_pair_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Power switch pair with optional short
// ****
module switch_pair_model (
  input wire logic clk,
  input wire logic low_side_gate_drive,
  input wire logic short_out,
  output logic trip_cmp_pin
);
  logic ring = 1'b0;
  always @(posedge clk) ring <= ~ring;
  // Outside low-side conduction the comparator only shows switching noise
  assign trip_cmp_pin = short_out && (low_side_gate_drive || ring);
endmodule
`default_nettype wire

// ===== bench/buck_fault_hiccup_sequencer_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Bench
// ****
module buck_fault_hiccup_sequencer_bench
  import hiccup_pkg::*;
;
  localparam int SS = 640;
  typedef struct {int code; logic [8:0] val;} note_type;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic enable_pin = 1'b0;
  logic pwm_request = 1'b0;
  logic short_out = 1'b0;
  logic force_high = 1'b0;
  sense_type trip_set_sense = '0;
  logic high_gate;
  logic low_gate;
  logic trip_cmp_pin;
  logic [5:0] ref_step;
  logic [8:0] trip_level_mv;
  logic overcurrent_guard;
  logic regulating;
  int seed = 88;
  int miscompares = 0;
  int n_compared = 0;
  int pcnt = 0;
  int gate_act = 0;
  int low_seen = 0;
  int mark = 0;
  note_type notes[$];
  event result_ev;

  always #5 clk = ~clk;

  always @(posedge clk) begin
    pcnt <= (pcnt == 332) ? 0 : pcnt + 1;
    pwm_request <= force_high || (pcnt < 200);
    gate_act <= gate_act + int'(high_gate || low_gate);
    low_seen <= low_seen + int'(low_gate);
  end

  buck_fault_hiccup_sequencer #(.POR_DELAY_CYCLES(200), .SAMPLE_CYCLES(100),
    .SOFT_START_CYCLES(SS), .REFRESH_CYCLES(1000)) dut (.clk(clk), .rst(rst),
    .enable_pin(enable_pin), .trip_cmp_pin(trip_cmp_pin), .trip_set_sense(trip_set_sense),
    .pwm_request(pwm_request), .high_side_gate_drive(high_gate),
    .low_side_gate_drive(low_gate), .ref_step(ref_step), .trip_level_mv(trip_level_mv),
    .overcurrent_guard(overcurrent_guard), .regulating(regulating));
  switch_pair_model partner (.clk(clk), .low_side_gate_drive(low_gate),
    .short_out(short_out), .trip_cmp_pin(trip_cmp_pin));

  task automatic close_out();
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic compare_val(input string what, input logic [8:0] exp, input logic [8:0] seen);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic expect_val(input int code, input logic [8:0] val);
    @(negedge clk);
    notes.push_back('{code, val});
    -> result_ev;
  endtask

  task automatic start_up(input logic open, input logic [8:0] lvl);
    @(posedge clk);
    enable_pin <= 1'b0;
    trip_set_sense <= '{open, lvl};
    cyc(10);
    expect_val(0, 9'h000);
    @(posedge clk);
    enable_pin <= 1'b1;
    cyc(1000);
    expect_val(0, 9'h001);
  endtask

  // ****
  // Result watcher
  // ****
  always begin
    note_type n;
    @(result_ev);
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.code)
        0: compare_val("regulating", n.val, {8'h00, regulating});
        1: compare_val("guard", n.val, {8'h00, overcurrent_guard});
        2: compare_val("trip_level", n.val, trip_level_mv);
        3: compare_val("gates_quiet", n.val, {8'h00, gate_act == mark});
        default: compare_val("low_cycles", n.val, 9'(low_seen - mark));
      endcase
    end
  end

  // ****
  // Main sequence
  // ****
  initial begin
    logic [8:0] lvl;
    cyc(2);
    rst <= 1'b0;
    lvl = 9'($unsigned($random(seed)) % 301);
    start_up(1'b0, lvl);
    expect_val(1, 9'h001);
    expect_val(2, lvl);
    @(posedge clk);
    short_out <= 1'b1;
    for (int i = 0; i < 1000 && regulating; i++) @(posedge clk);
    cyc(5);
    mark = gate_act;
    cyc(2 * SS - 40);
    expect_val(3, 9'h001);
    cyc(80);
    expect_val(3, 9'h000);
    cyc(2920);
    expect_val(0, 9'h000);
    @(posedge clk);
    short_out <= 1'b0;
    cyc(3 * SS + 400);
    expect_val(0, 9'h001);
    expect_val(2, lvl);
    start_up(1'b0, 9'h190);
    expect_val(1, 9'h000);
    start_up(1'b0, 9'h1F4);
    expect_val(2, 9'h1DB);
    start_up(1'b1, 9'h064);
    expect_val(1, 9'h000);
    @(posedge clk);
    short_out <= 1'b1;
    cyc(700);
    expect_val(0, 9'h001);
    @(posedge clk);
    force_high <= 1'b1;
    cyc(5);
    mark = low_seen;
    cyc(1700);
    expect_val(4, 9'h14D);
    @(posedge clk);
    short_out <= 1'b0;
    start_up(1'b0, lvl);
    cyc(700);
    mark = low_seen;
    cyc(998);
    expect_val(4, 9'(MIN_LOW_CYC));
    cyc(5);
    close_out();
  end

  initial begin
    cyc(40000);
    miscompares++;
    close_out();
  end
endmodule

bind buck_fault_hiccup_sequencer buck_fault_hiccup_sequencer_chk
  #(.REFRESH_CYCLES(REFRESH_CYCLES)) chk (.clk(clk), .rst(rst), .enable_pin(enable_pin),
  .trip_cmp_pin(trip_cmp_pin), .high_side_gate_drive(high_side_gate_drive),
  .low_side_gate_drive(low_side_gate_drive), .ref_step(ref_step),
  .trip_level_mv(trip_level_mv), .overcurrent_guard(overcurrent_guard),
  .regulating(regulating));
`default_nettype wire
